/* verilog/pd_filter_pkg.sv */
// Behaviour
// - A source-only port sends source capabilities and handles request and sink capabilities, a sink-only port sends request and sink capabilities and handles source capabilities, and each drops what its role lacks.
// - A dual-role power port both sends and handles source and sink capabilities, overriding the single-role settings.
// - Sources and sinks send and handle test messages, while a cable plug handles them but never sends one.
// - Without modal operation a downstream port may send discover identity and drops received discovery commands,
// an upstream port answers or negatively acknowledges discover identity and negatively acknowledges the rest,
// and a cable plug answers discover identity, negatively acknowledges discovery, enter and exit commands and drops attention.
// - Modal operation support overrides the plain downstream, upstream and cable plug settings for vendor commands.
// - With modal operation only a downstream port sends discovery, enter mode and exit mode commands.
// - With modal operation only an upstream port or a cable plug answers discovery, enter mode and exit mode commands.
// - An upstream port that is the power source may send discover identity, and otherwise an upstream port sends only attention.
// - A port using the high-speed lanes with power-role swap accepts a supply-swap request, other ports refuse it, and cable plugs neither send nor handle it.
// - A message not supported by the role is never sent and is dropped with no reply when received.
// - A received message marked for refusal is answered with a refusal message.
// - A received vendor command marked for negative acknowledgement gets a responder negative acknowledgement.
// - Drop, refusal and negative acknowledgement apply only in the ready state, and elsewhere an unexpected message is a protocol error.
package pd_filter_pkg;

  typedef enum logic [3:0] {
    msg_source_caps,
    msg_request,
    msg_bist,
    msg_sink_caps,
    msg_vconn_swap,
    msg_data_swap,
    msg_disc_identity,
    msg_disc_svids,
    msg_disc_modes,
    msg_enter_mode,
    msg_exit_mode,
    msg_attention
  } msg_kind_e;

  typedef enum logic {
    dir_rx,
    dir_tx
  } msg_dir_e;

  typedef enum logic [2:0] {
    act_none,
    act_handle,
    act_drop_silently,
    act_refuse_reply,
    act_negative_ack_reply,
    act_protocol_error,
    act_send,
    act_block
  } verdict_e;

  typedef struct packed {
    logic is_source;
    logic dual_power;
    logic is_dfp;
    logic dual_data;
    logic cable_plug;
    logic modal;
    logic vconn_swap_ok;
    logic ufp_answers_disc;
    logic dfp_takes_attention;
  } port_role_s;

  typedef struct packed {
    logic      valid;
    msg_dir_e  dir;
    msg_kind_e kind;
    logic      pe_ready;
  } msg_query_s;

  typedef struct packed {
    logic      valid;
    msg_dir_e  dir;
    msg_kind_e kind;
    verdict_e  action;
  } verdict_s;

  localparam verdict_s VERDICT_RESET = '{valid: 1'b0, dir: dir_rx, kind: msg_source_caps,
                                         action: act_none};

  // Discovery, enter and exit commands share one treatment
  function automatic logic is_mode_cmd(input msg_kind_e k);
    return (k == msg_disc_svids) || (k == msg_disc_modes) ||
           (k == msg_enter_mode) || (k == msg_exit_mode);
  endfunction

  function automatic logic is_vdm(input msg_kind_e k);
    return is_mode_cmd(k) || (k == msg_disc_identity) || (k == msg_attention);
  endfunction

endpackage

/* verilog/tx_permit_lut.sv */
`timescale 1ns/1ps
module tx_permit_lut
  import pd_filter_pkg::*;
(
  // Lookup
  input  wire pd_filter_pkg::msg_kind_e  kind,
  input  wire pd_filter_pkg::port_role_s role,
  output logic                           permit
);
  import pd_filter_pkg::*;

  logic sink_now;
  logic src_side;
  logic snk_side;

  always_comb begin
    sink_now = !role.is_source;
    src_side = role.is_source || role.dual_power;
    snk_side = sink_now || role.dual_power;
    permit   = 1'b0;
    if (!role.cable_plug) begin
      unique case (kind)
        msg_source_caps:   permit = src_side;
        msg_request:       permit = sink_now;
        msg_sink_caps:     permit = snk_side;
        msg_bist:          permit = 1'b1;
        msg_vconn_swap:    permit = 1'b1;
        msg_data_swap:     permit = role.dual_data;
        msg_disc_identity: permit = role.is_dfp || role.is_source;
        msg_disc_svids,
        msg_disc_modes,
        msg_enter_mode,
        msg_exit_mode:     permit = role.is_dfp && role.modal;
        msg_attention:     permit = !role.is_dfp;
        // Unused codes are never allowed out
        default:           permit = 1'b0;
      endcase
    end
  end

endmodule

/* verilog/pd_message_support_filter.sv */
`timescale 1ns/1ps
module pd_message_support_filter
  import pd_filter_pkg::*;
(
  // Clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       rst_n,
  // Port roles from the protocol engine
  input  wire pd_filter_pkg::port_role_s  role,
  // Message query
  input  wire pd_filter_pkg::msg_query_s  query,
  // Decision
  output pd_filter_pkg::verdict_s         verdict
);
  import pd_filter_pkg::*;

  typedef struct packed {
    verdict_s out;
  } filter_state_s;

  filter_state_s state_reg;
  filter_state_s state_next;
  logic          tx_ok;
  verdict_e      rx_act;

  ////////////////////////////////////////////////////////////////////////////
  // Transmit table
  tx_permit_lut u_tx_lut (
    .kind   (query.kind),
    .role   (role),
    .permit (tx_ok)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Receive table
  function automatic verdict_e rx_lookup(input msg_kind_e k, input port_role_s r);
    verdict_e a;
    a = act_drop_silently;
    if (r.cable_plug) begin
      if (k == msg_bist || k == msg_disc_identity) begin
        a = act_handle;
      end else if (is_mode_cmd(k)) begin
        a = r.modal ? act_handle : act_negative_ack_reply;
      end
    end else begin
      unique case (k)
        msg_source_caps: begin
          a = (!r.is_source || r.dual_power) ? act_handle : act_drop_silently;
        end
        msg_request: begin
          a = r.is_source ? act_handle : act_drop_silently;
        end
        msg_sink_caps: begin
          a = (r.is_source || r.dual_power) ? act_handle : act_drop_silently;
        end
        msg_bist: begin
          a = act_handle;
        end
        msg_vconn_swap: begin
          a = r.vconn_swap_ok ? act_handle : act_refuse_reply;
        end
        msg_data_swap: begin
          a = r.dual_data ? act_handle : act_refuse_reply;
        end
        msg_disc_identity: begin
          if (r.is_dfp) begin
            a = act_drop_silently;
          end else if (r.modal || r.ufp_answers_disc) begin
            a = act_handle;
          end else begin
            a = act_negative_ack_reply;
          end
        end
        msg_disc_svids,
        msg_disc_modes,
        msg_enter_mode,
        msg_exit_mode: begin
          if (r.is_dfp) begin
            a = act_drop_silently;
          end else begin
            a = r.modal ? act_handle : act_negative_ack_reply;
          end
        end
        msg_attention: begin
          if (r.is_dfp) begin
            a = r.dfp_takes_attention ? act_handle : act_drop_silently;
          end else begin
            a = act_negative_ack_reply;
          end
        end
        // Unused codes are treated as unsupported
        default: begin
          a = act_drop_silently;
        end
      endcase
    end
    return a;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Decision register
  always_comb begin
    rx_act             = rx_lookup(query.kind, role);
    state_next         = state_reg;
    state_next.out     = VERDICT_RESET;
    if (query.valid) begin
      state_next.out.valid = 1'b1;
      state_next.out.dir   = query.dir;
      state_next.out.kind  = query.kind;
      if (query.dir == dir_tx) begin
        state_next.out.action = tx_ok ? act_send : act_block;
      end else if (rx_act != act_handle && !query.pe_ready) begin
        state_next.out.action = act_protocol_error;
      end else begin
        state_next.out.action = rx_act;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '{out: VERDICT_RESET};
    end else begin
      state_reg <= state_next;
    end
  end

  assign verdict = state_reg.out;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  cable_no_send_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (query.valid && query.dir == dir_tx && role.cable_plug)
      |=> (verdict.valid && verdict.action == act_block))
    else $error("cable plug allowed to originate a message");

  one_clock_answer_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    query.valid |=> (verdict.valid && verdict.kind == $past(query.kind) &&
                     verdict.dir == $past(query.dir)))
    else $error("verdict not produced one clock after query");

  no_query_idle_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    !query.valid |=> (!verdict.valid && verdict.action == act_none))
    else $error("verdict without a query");

  sink_src_caps_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (query.valid && query.dir == dir_rx && query.kind == msg_source_caps &&
     query.pe_ready && !role.cable_plug && !role.is_source)
      |=> verdict.action == act_handle)
    else $error("sink failed to handle source capabilities");

  dual_snk_caps_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (query.valid && query.dir == dir_tx && query.kind == msg_sink_caps &&
     !role.cable_plug && role.dual_power)
      |=> verdict.action == act_send)
    else $error("dual-role port blocked from sending sink capabilities");

  modal_dfp_only_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (query.valid && query.dir == dir_tx && is_mode_cmd(query.kind) &&
     !(role.is_dfp && role.modal && !role.cable_plug))
      |=> verdict.action == act_block)
    else $error("mode command sent by a port that is not a modal downstream port");

  modal_answer_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (query.valid && query.dir == dir_rx && is_mode_cmd(query.kind) &&
     role.modal && (role.cable_plug || !role.is_dfp))
      |=> verdict.action == act_handle)
    else $error("modal responder did not handle a mode command");

  vconn_refuse_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (query.valid && query.dir == dir_rx && query.kind == msg_vconn_swap &&
     query.pe_ready && !role.cable_plug && !role.vconn_swap_ok)
      |=> verdict.action == act_refuse_reply)
    else $error("supply swap not refused");

  nak_nonmodal_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (query.valid && query.dir == dir_rx && is_mode_cmd(query.kind) &&
     query.pe_ready && !role.modal && (role.cable_plug || !role.is_dfp))
      |=> verdict.action == act_negative_ack_reply)
    else $error("mode command not negatively acknowledged");

  busy_error_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (query.valid && query.dir == dir_rx && !query.pe_ready)
      |=> (verdict.action inside {act_handle, act_protocol_error}))
    else $error("reply treatment applied outside the ready state");

  ufp_send_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (query.valid && query.dir == dir_tx && query.kind == msg_disc_identity &&
     !role.is_dfp && !role.is_source)
      |=> verdict.action == act_block)
    else $error("sinking upstream port allowed discover identity");

  tx_two_outcomes_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (query.valid && query.dir == dir_tx)
      |=> (verdict.action inside {act_send, act_block}))
    else $error("transmit query given a receive treatment");

  ready_no_error_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (query.valid && query.dir == dir_rx && query.pe_ready)
      |=> (verdict.action inside {act_handle, act_drop_silently, act_refuse_reply,
                                  act_negative_ack_reply}))
    else $error("ready-state message given a transmit or error treatment");

  data_swap_refuse_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (query.valid && query.dir == dir_rx && query.kind == msg_data_swap &&
     query.pe_ready && !role.cable_plug && !role.dual_data)
      |=> verdict.action == act_refuse_reply)
    else $error("data swap not refused by a single-role data port");

  cable_vconn_drop_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    (query.valid && query.dir == dir_rx && query.kind == msg_vconn_swap &&
     query.pe_ready && role.cable_plug)
      |=> verdict.action == act_drop_silently)
    else $error("cable plug answered a supply swap");

endmodule

/* sim/peer_port_model.sv */
`timescale 1ns/1ps
module peer_port_model
  import pd_filter_pkg::*;
(
  // Clock
  input  wire logic                  core_clk,
  // Message offered to the filter
  output pd_filter_pkg::msg_query_s  query
);
  initial begin
    query = '{valid: 1'b0, dir: dir_rx, kind: msg_source_caps, pe_ready: 1'b0};
  end

  // Offer one message from just after a falling edge; it is taken at the next rising edge
  task automatic offer(input msg_dir_e d, input msg_kind_e k, input logic rdy);
    query = '{valid: 1'b1, dir: d, kind: k, pe_ready: rdy};
    @(posedge core_clk);
    @(negedge core_clk);
  endtask

  // Released lines show a changed pattern, not the last message
  task automatic release_line();
    query.valid    = 1'b0;
    query.dir      = msg_dir_e'(~query.dir);
    query.kind     = msg_kind_e'(~query.kind);
    query.pe_ready = ~query.pe_ready;
  endtask
endmodule

/* sim/pd_message_support_filter_bench.sv */
`timescale 1ns/1ps
module pd_message_support_filter_bench;
  import pd_filter_pkg::*;
  logic       core_clk;
  logic       rst_n;
  port_role_s role;
  msg_query_s query;
  verdict_s   verdict;
  int         failures = 0;
  int         checks   = 0;

  pd_message_support_filter uut (
    .core_clk(core_clk),
    .rst_n   (rst_n),
    .role    (role),
    .query   (query),
    .verdict (verdict)
  );
  peer_port_model peer (
    .core_clk(core_clk),
    .query   (query)
  );

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Decision must be registered exactly one clock after the query
  task automatic probe(input msg_dir_e d, input msg_kind_e k, input logic rdy, input verdict_e exp);
    peer.offer(d, k, rdy);
    check("verdict valid", verdict.valid, 1'b1);
    check("verdict kind", verdict.kind, k);
    check("verdict dir", verdict.dir, d);
    check("verdict action", verdict.action, exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    rst_n = 1'b0;
    role  = '{default: 1'b0};
    repeat (8) @(negedge core_clk);
    check("reset valid", verdict.valid, 1'b0);
    check("reset action", verdict.action, act_none);
    rst_n = 1'b1;
    $display("test_reset done");
  endtask

  task automatic test_power_roles();
    role = '{is_source: 1'b1, default: 1'b0};
    probe(dir_tx, msg_source_caps, 1'b1, act_send);
    probe(dir_tx, msg_request, 1'b1, act_block);
    probe(dir_tx, msg_sink_caps, 1'b1, act_block);
    probe(dir_rx, msg_request, 1'b1, act_handle);
    probe(dir_rx, msg_sink_caps, 1'b1, act_handle);
    probe(dir_rx, msg_source_caps, 1'b1, act_drop_silently);
    probe(dir_tx, msg_bist, 1'b1, act_send);
    probe(dir_rx, msg_bist, 1'b1, act_handle);
    probe(dir_rx, msg_vconn_swap, 1'b1, act_refuse_reply);
    role = '{vconn_swap_ok: 1'b1, default: 1'b0};
    probe(dir_tx, msg_request, 1'b1, act_send);
    probe(dir_tx, msg_sink_caps, 1'b1, act_send);
    probe(dir_tx, msg_source_caps, 1'b1, act_block);
    probe(dir_rx, msg_source_caps, 1'b1, act_handle);
    probe(dir_rx, msg_request, 1'b1, act_drop_silently);
    probe(dir_rx, msg_sink_caps, 1'b1, act_drop_silently);
    probe(dir_rx, msg_vconn_swap, 1'b1, act_handle);
    role = '{dual_power: 1'b1, default: 1'b0};
    probe(dir_tx, msg_source_caps, 1'b1, act_send);
    probe(dir_rx, msg_sink_caps, 1'b1, act_handle);
    role = '{dual_power: 1'b1, is_source: 1'b1, default: 1'b0};
    probe(dir_tx, msg_sink_caps, 1'b1, act_send);
    probe(dir_rx, msg_source_caps, 1'b1, act_handle);
    $display("test_power_roles done");
  endtask

  task automatic test_cable_plug();
    role = '{cable_plug: 1'b1, is_source: 1'b1, vconn_swap_ok: 1'b1, default: 1'b0};
    probe(dir_tx, msg_source_caps, 1'b1, act_block);
    probe(dir_tx, msg_bist, 1'b1, act_block);
    probe(dir_rx, msg_bist, 1'b1, act_handle);
    probe(dir_rx, msg_disc_identity, 1'b1, act_handle);
    probe(dir_rx, msg_enter_mode, 1'b1, act_negative_ack_reply);
    probe(dir_rx, msg_vconn_swap, 1'b1, act_drop_silently);
    probe(dir_tx, msg_disc_identity, 1'b1, act_block);
    role.modal = 1'b1;
    probe(dir_rx, msg_exit_mode, 1'b1, act_handle);
    probe(dir_tx, msg_enter_mode, 1'b1, act_block);
    $display("test_cable_plug done");
  endtask

  task automatic test_plain_vdm();
    role = '{is_dfp: 1'b1, default: 1'b0};
    probe(dir_tx, msg_disc_identity, 1'b1, act_send);
    probe(dir_tx, msg_disc_svids, 1'b1, act_block);
    probe(dir_rx, msg_disc_identity, 1'b1, act_drop_silently);
    probe(dir_rx, msg_exit_mode, 1'b1, act_drop_silently);
    probe(dir_rx, msg_attention, 1'b1, act_drop_silently);
    probe(dir_tx, msg_attention, 1'b1, act_block);
    role = '{default: 1'b0};
    probe(dir_rx, msg_disc_identity, 1'b1, act_negative_ack_reply);
    probe(dir_rx, msg_disc_modes, 1'b1, act_negative_ack_reply);
    probe(dir_rx, msg_attention, 1'b1, act_negative_ack_reply);
    probe(dir_tx, msg_attention, 1'b1, act_send);
    probe(dir_tx, msg_disc_identity, 1'b1, act_block);
    role.ufp_answers_disc = 1'b1;
    probe(dir_rx, msg_disc_identity, 1'b1, act_handle);
    $display("test_plain_vdm done");
  endtask

  task automatic test_modal();
    role = '{is_dfp: 1'b1, modal: 1'b1, default: 1'b0};
    for (int i = msg_disc_identity; i <= msg_exit_mode; i++) begin
      probe(dir_tx, msg_kind_e'(i), 1'b1, act_send);
      probe(dir_rx, msg_kind_e'(i), 1'b1, act_drop_silently);
    end
    role = '{is_source: 1'b1, modal: 1'b1, default: 1'b0};
    probe(dir_tx, msg_disc_identity, 1'b1, act_send);
    for (int i = msg_disc_identity; i <= msg_exit_mode; i++) begin
      probe(dir_rx, msg_kind_e'(i), 1'b1, act_handle);
    end
    for (int i = msg_disc_svids; i <= msg_exit_mode; i++) begin
      probe(dir_tx, msg_kind_e'(i), 1'b1, act_block);
    end
    $display("test_modal done");
  endtask

  task automatic test_side_entries();
    role = '{dual_data: 1'b1, default: 1'b0};
    probe(dir_tx, msg_data_swap, 1'b1, act_send);
    probe(dir_rx, msg_data_swap, 1'b1, act_handle);
    probe(dir_tx, msg_vconn_swap, 1'b1, act_send);
    role = '{default: 1'b0};
    probe(dir_tx, msg_data_swap, 1'b1, act_block);
    probe(dir_rx, msg_data_swap, 1'b1, act_refuse_reply);
    role = '{is_dfp: 1'b1, dfp_takes_attention: 1'b1, default: 1'b0};
    probe(dir_rx, msg_attention, 1'b1, act_handle);
    role = '{cable_plug: 1'b1, default: 1'b0};
    probe(dir_tx, msg_vconn_swap, 1'b1, act_block);
    $display("test_side_entries done");
  endtask

  // Reset in mid-run clears a standing verdict at once
  task automatic test_mid_reset();
    peer.offer(dir_rx, msg_bist, 1'b1);
    check("pre reset valid", verdict.valid, 1'b1);
    rst_n = 1'b0;
    #1;
    check("mid reset valid", verdict.valid, 1'b0);
    check("mid reset action", verdict.action, act_none);
    @(negedge core_clk);
    rst_n = 1'b1;
    probe(dir_rx, msg_bist, 1'b1, act_handle);
    $display("test_mid_reset done");
  endtask

  task automatic test_not_ready();
    role = '{default: 1'b0};
    probe(dir_rx, msg_vconn_swap, 1'b0, act_protocol_error);
    probe(dir_rx, msg_request, 1'b0, act_protocol_error);
    probe(dir_rx, msg_disc_modes, 1'b0, act_protocol_error);
    probe(dir_rx, msg_source_caps, 1'b0, act_handle);
    peer.release_line();
    @(negedge core_clk);
    check("idle valid", verdict.valid, 1'b0);
    check("idle action", verdict.action, act_none);
    $display("test_not_ready done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // About 85 cycles of tests; the watchdog allows about thirteen times that
  initial begin
    #(50 * 1100);
    failures++;
    end_sim();
  end

  initial begin
    test_reset();
    test_power_roles();
    test_cable_plug();
    test_plain_vdm();
    test_modal();
    test_side_entries();
    test_mid_reset();
    test_not_ready();
    end_sim();
  end
endmodule
